/* File: hdl/iseb_defs.svh */
// offsets, reset values and field constants for the interrupt set-enable bank
`ifndef ISEB_DEFS_SVH
`define ISEB_DEFS_SVH
`define ISEB_ADDR_W 8
`define ISEB_ENABLE_SET_OFF 8'h00
`define ISEB_ENABLE_RESET 32'h00000000
`define ISEB_IRQ_COUNT 32
`define ISEB_UNMAPPED_READ 32'h00000000
`endif

/* File: hdl/iseb_pkg.sv */
// types shared by the interrupt set-enable bank
`default_nettype none
`include "iseb_defs.svh"
package iseb_pkg;
  // one register-port request, carried as a unit
  typedef struct packed {
    logic [`ISEB_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iseb_req_t;
  // decode result of a register access
  typedef enum logic [1:0] {
    ISEB_ACC_IDLE,
    ISEB_ACC_SET,
    ISEB_ACC_OTHER
  } iseb_acc_t;
endpackage
`default_nettype wire

/* File: hdl/iseb_enable_store.sv */
// storage bits for the per-interrupt enable state, set-only on write
`timescale 1ns/1ps
`default_nettype none
`include "iseb_defs.svh"
module iseb_enable_store
  import iseb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic set_en_i,
  input wire logic [31:0] set_mask_i,
  output logic [31:0] enable_o
);
  logic [31:0] enable_bits; // one flop per interrupt
  logic [31:0] next_enable_bits;

  // ones set a bit, zeros keep it; nothing here ever clears
  always_comb begin
    next_enable_bits = enable_bits;
    if (set_en_i) begin
      next_enable_bits = enable_bits | set_mask_i;
    end
  end

  // register stage, cleared at reset so all start disabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_bits <= `ISEB_ENABLE_RESET;
    end else begin
      enable_bits <= next_enable_bits;
    end
  end

  assign enable_o = enable_bits;
endmodule
`default_nettype wire

/* File: hdl/iseb_top.sv */
// What this block does
// - one 32-bit enable-set field, bit per interrupt
// - register bit n controls interrupt n
// - writing one enables that interrupt, sticky
// - writing zero leaves enable unchanged
// - read returns current enable state of each
// - reset clears every enable bit
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "iseb_defs.svh"
module iseb_top
  import iseb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [`ISEB_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [`ISEB_IRQ_COUNT-1:0] irq_enable_o
);
  logic rst_sync_a; // first reset stage, read only by second
  logic rst_sync_b; // released reset used everywhere else
  iseb_req_t req; // bundled request from the port
  iseb_acc_t acc; // decoded access kind
  logic [31:0] enable_bits; // stored enables
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] irq_enable;
  logic [31:0] next_irq_enable;

  // decode one address against the single mapped offset
  function automatic iseb_acc_t iseb_decode(input logic [`ISEB_ADDR_W-1:0] a, input logic strobe);
    iseb_acc_t k;
    k = ISEB_ACC_IDLE;
    if (strobe) begin
      k = (a == `ISEB_ENABLE_SET_OFF) ? ISEB_ACC_SET : ISEB_ACC_OTHER;
    end
    return k;
  endfunction

  // reset release through two flops, assert stays asynchronous
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_a <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_sync_a <= 1'b1;
      rst_sync_b <= rst_sync_a;
    end
  end

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign acc = iseb_decode(req.addr, req.wr | req.rd);

  // enable storage; writes to other offsets are dropped
  iseb_enable_store u_store (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_sync_b),
    .set_en_i(req.wr && (acc == ISEB_ACC_SET)),
    .set_mask_i(req.wdata),
    .enable_o(enable_bits)
  );

  // read data and enable outputs, both registered
  always_comb begin
    next_rdata = rdata;
    next_irq_enable = enable_bits;
    if (req.rd) begin
      case (acc)
        ISEB_ACC_SET: begin
          next_rdata = enable_bits;
        end
        ISEB_ACC_OTHER: begin
          next_rdata = `ISEB_UNMAPPED_READ; // unmapped reads as zero
        end
        default: begin
          next_rdata = `ISEB_UNMAPPED_READ;
        end
      endcase
    end else begin
      next_rdata = `ISEB_UNMAPPED_READ; // data valid only the cycle after read
    end
  end

  // output flops; irq enable lags storage by one cycle
  always_ff @(posedge core_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata <= `ISEB_ENABLE_RESET;
      irq_enable <= `ISEB_ENABLE_RESET;
    end else begin
      rdata <= next_rdata;
      irq_enable <= next_irq_enable;
    end
  end

  assign reg_rdata_o = rdata;
  assign irq_enable_o = irq_enable;
endmodule
`default_nettype wire

/* File: tb/iseb_monitor.sv */
// port checker for the set-enable bank
`timescale 1ns/1ps
`default_nettype none
module iseb_monitor (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [31:0] irq_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // the only mapped offset
  wire hit = reg_addr_i == 8'h00;
  // two-cycle lag: storage takes the write, the enable copy follows
  chk_set_merge: assert property (irq_enable_o == ($past(irq_enable_o) |
    ($past(reg_wr_i && hit, 2) ? $past(reg_wdata_i, 2) : 32'h0))) else $error("merge");
  chk_read_value: assert property (reg_rd_i && hit |=> reg_rdata_o == irq_enable_o) else $error("read");
  chk_read_zero: assert property (!$past(reg_rd_i && hit) |-> reg_rdata_o == 32'h0) else $error("zero");
  // two low samples, so the async clear has surely landed
  chk_reset_zero: assert property (disable iff (1'b0) !rst_n_i [*2] |-> !(irq_enable_o | reg_rdata_o))
    else $error("reset");
  // a stored one never falls while reset stays away; only reset clears
  chk_sticky_bits: assert property (($past(irq_enable_o) & ~irq_enable_o) == 32'h0) else $error("sticky");
  // an all-zero write to the mapped offset changes nothing
  chk_zero_nochange: assert property (reg_wr_i && hit && reg_wdata_i == 32'h0 |-> ##2 $stable(irq_enable_o))
    else $error("zero write");
  // writes to any other offset never reach the enables
  chk_unmapped_write: assert property (reg_wr_i && !hit |-> ##2 $stable(irq_enable_o))
    else $error("unmapped write");
  cover property (reg_wr_i && hit);
  cover property (reg_rd_i && !hit);
  cover property (&irq_enable_o);
endmodule
bind iseb_top iseb_monitor mon (.*);
`default_nettype wire

/* File: tb/iseb_top_test.sv */
// directed bench for the set-enable bank
`timescale 1ns/1ps
`default_nettype none
module iseb_top_test;
  logic core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, e = 5, reg_rdata_o, irq_enable_o;
  int err_count = 0, n_tests = 0, cyc = 0;
  iseb_top dut (.*);
  initial forever #5 core_clk_i = ~core_clk_i;
  // whole run is near 140 cycles
  always @(posedge core_clk_i) if (++cyc == 500) summarize(1);
  task automatic bus(logic w, r, logic [7:0] ad, logic [31:0] v);
    @(posedge core_clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, r, ad, v};
  endtask
  // one compare; !== keeps an unknown from slipping through
  task automatic check(logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(logic [7:0] ad, logic [31:0] x, y);
    bus(0, 1, ad, 0);
    bus(0, 0, 0, 0);
    #1 check(reg_rdata_o, x);
    check(irq_enable_o, y);
    $display("read %0d done", n_tests);
  endtask
  task automatic summarize(bit late);
    err_count += late;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1;
    repeat (4) @(posedge core_clk_i);
    rdc(0, 0, 0);
    bus(1, 0, 0, 5);
    bus(1, 0, 8'h04, 32'hFFFF0000);
    bus(1, 0, 0, 0);
    rdc(0, 5, 5);
    rdc(8'h04, 0, 5);
    for (int i = 0; i < 32; i++) begin
      e |= 32'h1 << i;
      bus(1, 0, 0, 32'h1 << i);
      rdc(0, e, e);
    end
    // mid-run reset must clear bits that are really set
    @(posedge core_clk_i);
    rst_n_i <= 0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1;
    repeat (4) @(posedge core_clk_i);
    rdc(0, 0, 0);
    bus(1, 0, 0, 32'h80000001);
    rdc(0, 32'h80000001, 32'h80000001);
    summarize(0);
  end
endmodule
`default_nettype wire
